// ==== rtl/csp_serial_port.sv ====
// Converter serial port: sclk-side shifter, oscillator-side sequencing
`timescale 1ns/1ns
// Behaviour
// - Data line stays released except while shifting read data out.
// - Select going high mid-read does not release the data line.
// - Clock edges while select is high are ignored.
// - Input bits are captured on the falling sclk edge.
// - Output bits change after each rising sclk edge.
// - Read drive starts eight to ten periods after instruction.
// - Drive released four to six periods after last read falling edge.
// - Stalled transfer resets the serial interface, registers kept.
// - Configuration bit selects MSB-first or LSB-first bytes.
// - Data input register loads on the last bit of last byte.
module csp_serial_port import csp_pkg::*; #(
	parameter int TIMEOUT_CYC = TIMEOUT_PER,
	parameter int MEM_DEPTH = REG_DEPTH
) (
	// System, clk is master_osc_input
	input wire logic clk,
	input wire logic rstn,
	// Serial link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdio_in,
	output logic sdio_out,
	output logic sdio_oe_n,
	// Converter side
	output logic [DIR_W-1:0] dir_value,
	output logic dir_load,
	output logic lsb_first
);
	localparam int TW = $clog2(TIMEOUT_CYC + 1);

	if (TIMEOUT_CYC < 64 || MEM_DEPTH != REG_DEPTH) begin : g_chk
		$error("csp_serial_port: unsupported parameters");
	end

	function automatic logic [7:0] order8(input logic [7:0] b, input logic lsb);
		logic [7:0] r;
		r = b;
		for (int i = 0; i < 8; i++) begin
			r[i] = lsb ? b[7-i] : b[i];
		end
		return r;
	endfunction : order8

	// Link domain
	logic link_clear;
	logic link_rst_n;
	logic [2:0] bit_cnt;
	logic [6:0] rx_shift;
	logic [7:0] rx_byte;
	logic byte_tgl;
	logic edge_tgl;
	logic [7:0] tx_shift;
	logic [7:0] tx_word;

	// Timeout clears the link side without touching stored registers
	assign link_rst_n = rstn & ~link_clear;

	always_ff @(negedge sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			bit_cnt <= 3'h0;
			rx_shift <= 7'h00;
			rx_byte <= 8'h00;
			byte_tgl <= 1'b0;
			edge_tgl <= 1'b0;
		end else if (!cs_n) begin
			edge_tgl <= ~edge_tgl;
			bit_cnt <= bit_cnt + 3'h1;
			rx_shift <= {rx_shift[5:0], sdio_in};
			if (bit_cnt == 3'h7) begin
				rx_byte <= {rx_shift, sdio_in};
				byte_tgl <= ~byte_tgl;
			end
		end
	end

	// tx_word is settled long before the first rise of a byte
	always_ff @(posedge sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			tx_shift <= 8'h00;
		end else if (!cs_n) begin
			tx_shift <= (bit_cnt == 3'h0) ? tx_word : {tx_shift[6:0], 1'b0};
		end
	end
	assign sdio_out = tx_shift[7];

	// Oscillator domain
	logic [2:0] byte_sync;
	logic [2:0] edge_sync;
	logic byte_ev;
	logic edge_ev;
	logic [7:0] byte_in;
	csp_state_type state;
	logic is_read;
	logic [1:0] bytes_left;
	logic [ADDR_W-1:0] addr;
	logic [3:0] cnt;
	logic [TW-1:0] tmo_cnt;
	logic mid_byte;
	logic tmo_hit;
	logic [1:0] ld_pipe;
	logic [7:0] rdata;
	logic [DIR_W-1:0] dir_stage;
	logic [DIR_W-1:0] next_dir_stage;
	logic dir_touched;
	logic wr_en;
	logic last_wr;
	logic ins_ev;

	assign byte_ev = byte_sync[1] ^ byte_sync[2];
	assign edge_ev = edge_sync[1] ^ edge_sync[2];
	assign byte_in = order8(rx_byte, lsb_first);
	assign ins_ev = byte_ev && state == ST_IDLE;
	assign wr_en = byte_ev && state == ST_XFER && !is_read;
	assign last_wr = wr_en && bytes_left == 2'h0;
	assign tmo_hit = tmo_cnt == TW'(TIMEOUT_CYC - 1);

	always_comb begin
		next_dir_stage = dir_stage;
		if (wr_en && addr == DIR_ADDR_HI) next_dir_stage[23:16] = byte_in;
		if (wr_en && addr == DIR_ADDR_MID) next_dir_stage[15:8] = byte_in;
		if (wr_en && addr == DIR_ADDR_LO) next_dir_stage[7:0] = byte_in;
	end

	csp_regmem #(.WIDTH(8), .DEPTH(MEM_DEPTH)) u_mem (
		.clk(clk),
		.we(wr_en),
		.waddr(addr),
		.wdata(byte_in),
		.raddr(addr),
		.rdata(rdata)
	);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			byte_sync <= 3'h0;
			edge_sync <= 3'h0;
		end else if (link_clear) begin
			byte_sync <= 3'h0;
			edge_sync <= 3'h0;
		end else begin
			byte_sync <= {byte_sync[1:0], byte_tgl};
			edge_sync <= {edge_sync[1:0], edge_tgl};
		end
	end

	// Each falling sclk edge taken while selected restarts the stall timer
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tmo_cnt <= '0;
			mid_byte <= 1'b0;
			link_clear <= 1'b0;
		end else begin
			link_clear <= tmo_hit;
			if (edge_ev) mid_byte <= 1'b1;
			if (byte_ev || tmo_hit) mid_byte <= 1'b0;
			if (edge_ev || tmo_hit || (state == ST_IDLE && !mid_byte)) tmo_cnt <= '0;
			else tmo_cnt <= tmo_cnt + TW'(1);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= ST_IDLE;
			is_read <= 1'b0;
			bytes_left <= 2'h0;
			addr <= '0;
			cnt <= 4'h0;
			sdio_oe_n <= 1'b1;
			ld_pipe <= 2'h0;
			tx_word <= 8'h00;
		end else begin
			ld_pipe <= {ld_pipe[0], 1'b0};
			if (ld_pipe[1]) tx_word <= order8(rdata, lsb_first);
			cnt <= cnt + 4'h1;
			case (state)
				ST_IDLE: begin
					if (ins_ev) begin
						is_read <= byte_in[INS_RW_BIT];
						bytes_left <= byte_in[INS_MB_HI:INS_MB_LO];
						addr <= byte_in[INS_ADDR_HI:0];
						ld_pipe <= 2'h1;
						cnt <= 4'h0;
						state <= byte_in[INS_RW_BIT] ? ST_OE_WAIT : ST_XFER;
					end
				end
				ST_OE_WAIT: begin
					if (cnt == OE_ON_LAST) begin
						sdio_oe_n <= 1'b0;
						state <= ST_XFER;
					end
				end
				ST_XFER: begin
					if (byte_ev) begin
						cnt <= 4'h0;
						addr <= addr + ADDR_W'(1);
						bytes_left <= bytes_left - 2'h1;
						ld_pipe <= 2'h1;
						if (bytes_left == 2'h0) state <= is_read ? ST_RELEASE : ST_IDLE;
					end
				end
				ST_RELEASE: begin
					if (cnt == OE_OFF_LAST) begin
						sdio_oe_n <= 1'b1;
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
			// Stall recovery wins over everything; select never releases the line
			if (tmo_hit) begin
				state <= ST_IDLE;
				sdio_oe_n <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dir_stage <= DIR_RESET;
			dir_value <= DIR_RESET;
			dir_load <= 1'b0;
			dir_touched <= 1'b0;
			lsb_first <= 1'b0;
		end else begin
			dir_stage <= next_dir_stage;
			dir_load <= 1'b0;
			if (ins_ev) dir_touched <= 1'b0;
			if (wr_en && addr <= DIR_ADDR_LO) dir_touched <= 1'b1;
			if (last_wr && (dir_touched || addr <= DIR_ADDR_LO)) begin
				dir_value <= next_dir_stage;
				dir_load <= 1'b1;
			end
			if (wr_en && addr == CFG_ADDR) lsb_first <= byte_in[CFG_LSB_BIT];
		end
	end

	AST_OE_ONLY_READ: assert property (@(posedge clk) disable iff (!rstn)
		!sdio_oe_n |-> is_read && (state == ST_XFER || state == ST_RELEASE))
		else $error("data line driven outside a read");
	AST_CS_NO_RELEASE: assert property (@(posedge clk) disable iff (!rstn)
		!sdio_oe_n && state == ST_XFER && !byte_ev && !tmo_hit |=> !sdio_oe_n)
		else $error("data line released mid-read");
	AST_CS_GATES_EDGES: assert property (@(negedge sclk) disable iff (!link_rst_n)
		cs_n |=> $stable(bit_cnt))
		else $error("edge counted with select high");
	AST_OE_ON_DELAY: assert property (@(posedge clk) disable iff (!rstn)
		$rose(state == ST_OE_WAIT) |-> sdio_oe_n [*6] ##1 !sdio_oe_n)
		else $error("read drive start out of window");
	AST_OE_OFF_DELAY: assert property (@(posedge clk) disable iff (!rstn)
		$rose(state == ST_RELEASE) |-> !sdio_oe_n [*2] ##1 sdio_oe_n)
		else $error("read drive release out of window");
	AST_TIMEOUT: assert property (@(posedge clk) disable iff (!rstn)
		tmo_hit |=> link_clear && state == ST_IDLE && sdio_oe_n)
		else $error("stall did not reset the interface");
	AST_BIT_ORDER: assert property (@(posedge clk) disable iff (!rstn)
		byte_ev |-> byte_in[7] == (lsb_first ? rx_byte[0] : rx_byte[7]))
		else $error("bit order not applied");
	AST_DIR_LOAD: assert property (@(posedge clk) disable iff (!rstn)
		dir_load |-> dir_value == $past(next_dir_stage) ##1 !dir_load)
		else $error("data input register load wrong");
endmodule : csp_serial_port

// ==== common/csp_pkg.sv ====
// Constants shared by the converter serial port
package csp_pkg;
	// Instruction byte layout
	localparam int INS_RW_BIT = 7;
	localparam int INS_MB_HI = 6;
	localparam int INS_MB_LO = 5;
	localparam int INS_ADDR_HI = 3;
	// Register map
	localparam int ADDR_W = 4;
	localparam int REG_DEPTH = 16;
	localparam int DIR_W = 24;
	localparam logic [3:0] DIR_ADDR_HI = 4'h0;
	localparam logic [3:0] DIR_ADDR_MID = 4'h1;
	localparam logic [3:0] DIR_ADDR_LO = 4'h2;
	localparam logic [3:0] CFG_ADDR = 4'h4;
	localparam int CFG_LSB_BIT = 2;
	localparam logic [DIR_W-1:0] DIR_RESET = 24'h000000;
	// Turn-around timing in master_osc_input periods (one clk cycle each)
	localparam int SYNC_LAT = 2;
	localparam int OE_ON_PER = 8;
	localparam int OE_OFF_PER = 4;
	localparam int OE_ON_CYC = OE_ON_PER - SYNC_LAT;
	localparam int OE_OFF_CYC = OE_OFF_PER - SYNC_LAT;
	localparam logic [3:0] OE_ON_LAST = 4'(OE_ON_CYC - 1);
	localparam logic [3:0] OE_OFF_LAST = 4'(OE_OFF_CYC - 1);
	// Stall timeout, referenced to a 2.5 MHz oscillator
	localparam int TIMEOUT_MS = 100;
	localparam int XIN_REF_HZ = 2500000;
	localparam int TIMEOUT_PER = TIMEOUT_MS * (XIN_REF_HZ / 1000);
	typedef enum logic [1:0] {ST_IDLE, ST_OE_WAIT, ST_XFER, ST_RELEASE} csp_state_type;
endpackage : csp_pkg

// ==== rtl/csp_regmem.sv ====
// Byte-wide register storage with registered read data
`timescale 1ns/1ns
module csp_regmem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock
	input wire logic clk,
	// Write port
	input wire logic we,
	input wire logic [$clog2(DEPTH)-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	// Read port
	input wire logic [$clog2(DEPTH)-1:0] raddr,
	output logic [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] mem [DEPTH];

	if (WIDTH < 1 || DEPTH < 2) begin : g_chk
		$error("csp_regmem: bad geometry");
	end

	// No reset on the array keeps it a plain RAM
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule : csp_regmem

// ==== bench/csp_host_model.sv ====
// Host controller model driving the converter serial link
`timescale 1ns/1ns
module csp_host_model (
	// Link timebase, 30 ns
	input wire logic tick,
	// Serial link
	input wire logic line,
	output logic sclk,
	output logic cs_n,
	output logic host_oe,
	output logic host_bit
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		host_oe = 1'b0;
		host_bit = 1'b0;
	end
	// Gaps are whole ticks, rounded up past the oscillator minimum
	task automatic wt(input int n);
		repeat (n) @(posedge tick);
		#1;
	endtask : wt
	task automatic sel(input logic v);
		cs_n = v;
		wt(v ? 15 : 8);
	endtask : sel
	task automatic bit_cyc(input logic drv, input logic b, output logic got);
		host_oe = drv;
		host_bit = b;
		sclk = 1'b1;
		wt(5);
		got = line;
		sclk = 1'b0;
		wt(5);
	endtask : bit_cyc
	task automatic byte_io(input logic drv, input logic lsb, input logic [7:0] b,
		output logic [7:0] got);
		logic g;
		for (int i = 0; i < 8; i++) begin
			bit_cyc(drv, b[lsb ? i : 7 - i], g);
			got[lsb ? i : 7 - i] = g;
		end
		host_oe = 1'b0;
	endtask : byte_io
	task automatic xfer(input logic rd, input int n, input logic [3:0] addr,
		input logic [23:0] d, input logic lsb, output logic [23:0] q);
		logic [7:0] g;
		byte_io(1'b1, lsb, {rd, 2'(n - 1), 1'b0, addr}, g);
		wt(9);
		q = '0;
		for (int k = n - 1; k >= 0; k--) begin
			byte_io(!rd, lsb, d[8 * k +: 8], g);
			q[8 * k +: 8] = g;
		end
		wt(28);
	endtask : xfer
endmodule : csp_host_model

// ==== bench/csp_serial_port_test.sv ====
// Self-checking bench for the converter serial port
`timescale 1ns/1ns
module csp_serial_port_test import csp_pkg::*;;
	typedef struct {logic [3:0] a; int n; logic [23:0] d; logic [23:0] dir;} csp_row_type;
	csp_row_type rows[3] = '{'{4'h0, 3, 24'h12A5C3, 24'h12A5C3},
		'{4'h1, 2, 24'h007E81, 24'h127E81}, '{4'h2, 1, 24'h0000F0, 24'h127EF0}};
	logic clk, rstn, tick, sclk, cs_n, host_oe, host_bit, line, drove, stall;
	logic sdio_out, sdio_oe_n, dir_load, lsb_first;
	logic [DIR_W-1:0] dir_value;
	int n_fail = 0;
	int checked = 0;
	int loads = 0;
	int cyc = 0;
	realtime t_fall = 0;
	// Released line shows the inverse of the last bit, never a held value
	assign line = !sdio_oe_n ? sdio_out : (host_oe ? host_bit : ~host_bit);
	csp_serial_port #(.TIMEOUT_CYC(200)) csp_serial_port_i (.clk(clk), .rstn(rstn),
		.sclk(sclk), .cs_n(cs_n), .sdio_in(line), .sdio_out(sdio_out),
		.sdio_oe_n(sdio_oe_n), .dir_value(dir_value), .dir_load(dir_load),
		.lsb_first(lsb_first));
	csp_host_model csp_host_model_i (.tick(tick), .line(line), .sclk(sclk), .cs_n(cs_n),
		.host_oe(host_oe), .host_bit(host_bit));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		tick = 1'b0;
		#7;
		forever #15 tick = ~tick;
	end
	task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s: expected %h, seen %h", what, exp, got);
		end
	endtask : check
	task automatic close_out();
		$display("counts: %0d checked, %0d wrong", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : close_out
	always @(posedge clk) begin
		cyc++;
		if (dir_load === 1'b1) loads++;
		if (sdio_oe_n === 1'b0) drove = 1'b1;
		if (cyc == 20000) begin
			n_fail++;
			close_out();
		end
	end
	always @(negedge sclk) if (cs_n === 1'b0) t_fall = $realtime;
	// Windows are the documented eight-to-ten and four-to-six oscillator periods
	always @(negedge sdio_oe_n) check("drive delay", 32'(($realtime - t_fall) >= 160.0
		&& ($realtime - t_fall) <= 200.0), 1);
	always @(negedge sdio_oe_n) check("host released", host_oe, 0);
	always @(posedge sdio_oe_n) if (rstn && !stall) check("release delay",
		32'(($realtime - t_fall) >= 80.0 && ($realtime - t_fall) <= 120.0), 1);
	initial begin
		logic [23:0] q;
		int l0;
		rstn = 1'b0;
		drove = 1'b0;
		stall = 1'b0;
		repeat (12) @(posedge clk);
		#1;
		check("oe_n reset", sdio_oe_n, 1);
		check("dir reset", dir_value, DIR_RESET);
		check("order reset", lsb_first, 0);
		rstn = 1'b1;
		$display("reset done");
		// Stand-in for the oscillator settling wait before any link activity
		repeat (4) @(posedge clk);
		#1;
		csp_host_model_i.sel(1'b0);
		foreach (rows[r]) begin
			l0 = loads;
			drove = 1'b0;
			csp_host_model_i.xfer(1'b0, rows[r].n, rows[r].a, rows[r].d, 1'b0, q);
			check("dir value", dir_value, rows[r].dir);
			check("dir loads", loads - l0, 1);
			check("no drive on write", drove, 0);
			csp_host_model_i.xfer(1'b1, rows[r].n, rows[r].a, 24'h0, 1'b0, q);
			check("read back", q, rows[r].d);
			$display("row %0d done", r);
		end
		// Order switch: the switching transfer itself still goes MSB first
		csp_host_model_i.xfer(1'b0, 1, CFG_ADDR, 24'(1 << CFG_LSB_BIT), 1'b0, q);
		check("lsb first", lsb_first, 1);
		csp_host_model_i.xfer(1'b0, 1, DIR_ADDR_LO, 24'h000031, 1'b1, q);
		check("lsb dir", dir_value, 24'h127E31);
		csp_host_model_i.xfer(1'b1, 1, DIR_ADDR_LO, 24'h0, 1'b1, q);
		check("lsb read", q, 24'h000031);
		csp_host_model_i.xfer(1'b0, 1, CFG_ADDR, 24'h0, 1'b1, q);
		check("msb first", lsb_first, 0);
		$display("bit order done");
		csp_host_model_i.sel(1'b1);
		l0 = loads;
		csp_host_model_i.xfer(1'b0, 1, DIR_ADDR_LO, 24'h0000AA, 1'b0, q);
		check("deselected dir", dir_value, 24'h127E31);
		check("deselected load", loads - l0, 0);
		csp_host_model_i.sel(1'b0);
		$display("deselect done");
		// Read cut short by select, then left to stall past the timeout
		stall = 1'b1;
		csp_host_model_i.byte_io(1'b1, 1'b0, {1'b1, 2'b00, 1'b0, DIR_ADDR_HI}, q[7:0]);
		csp_host_model_i.wt(9);
		repeat (3) csp_host_model_i.bit_cyc(1'b0, 1'b0, q[0]);
		csp_host_model_i.sel(1'b1);
		check("drive kept", sdio_oe_n, 0);
		repeat (400) @(posedge clk);
		#1;
		check("stall release", sdio_oe_n, 1);
		stall = 1'b0;
		csp_host_model_i.sel(1'b0);
		csp_host_model_i.xfer(1'b1, 1, DIR_ADDR_HI, 24'h0, 1'b0, q);
		check("kept register", q, 24'h000012);
		$display("stall done");
		close_out();
	end
endmodule : csp_serial_port_test
